// ### pic_cpu_model.sv
// processor-side model: takes the encoded level each clock
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
  // clock
  input wire logic I_CLK,
  // level in, level taken out
  input wire logic [3:0] i_level,
  output logic [3:0] o_taken
);
  // no acknowledge path; the core just samples the lines
  always_ff @(posedge I_CLK) begin
    o_taken <= i_level;
  end
endmodule : pic_cpu_model
`default_nettype wire

// ### pic_ctrl.sv
// priority interrupt controller with an APB register slave
//
// Summary of operation
// - current request given to processor as 4-bit encoded level, zero means none
// - software request available on each of levels 1 to 15
// - timer 10, floppy 11, serial/keyboard/mouse 12, audio 13, cpu timer 14
// - expansion requests 1..7 go to levels 2,3,5,7,9,11,13, system bits 13:7
// - parallel port level 3, disk bus level 4, network level 6
// - hardware errors and power-down request raise level 15
// - processor pending register shows software and hardware bits per level
// - clear location clears software bits written one and level 15 latch
// - set location sets software bits written one, raising that level
// - system group enables and clears each hardware request except audio, cpu timer and parallel port
// - mask bit 31 disables all interrupt levels, reserved in system pending
// - module error bit 30, floppy bit 22, level-10 timer bit 19
// - disk bus 18, network 16, serial 15, keyboard/mouse 14, 6:0 reserved
// - mask read at one word, changed via adjacent clear and set words
`timescale 1ns/1ps
`default_nettype none

module pic_ctrl
  import pic_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // register bus
  input wire pic_apb_req_t I_APB,
  output pic_apb_rsp_t O_APB,
  // hardware request sources
  input wire pic_src_t I_SRC,
  // processor and interrupt outputs
  output logic [3:0] O_CPU_IRQ_LEVEL,
  output logic O_IRQ
);

  // one-hot register select from a byte address
  function automatic logic [NUM_REGS-1:0] reg_sel(input logic [31:0] a);
    logic [NUM_REGS-1:0] s;
    s = '0;
    s[0] = (a == CPU_IRQ_PENDING_ADDR);
    s[1] = (a == CPU_IRQ_CLEAR_ADDR);
    s[2] = (a == CPU_SOFT_IRQ_SET_ADDR);
    s[3] = (a == SYS_IRQ_PENDING_ADDR);
    s[4] = (a == SYS_IRQ_MASK_ADDR);
    s[5] = (a == SYS_IRQ_MASK_CLEAR_ADDR);
    s[6] = (a == SYS_IRQ_MASK_SET_ADDR);
    s[7] = (a == EVT_STATUS_ADDR);
    s[8] = (a == EVT_CLEAR_ADDR);
    s[9] = (a == EVT_ENABLE_ADDR);
    return s;
  endfunction : reg_sel

  // highest set level of a request vector, zero when none
  function automatic logic [3:0] top_level(input logic [15:1] req);
    logic [3:0] lvl;
    lvl = 4'h0;
    for (int n = 1; n <= 15; n++) begin
      if (req[n]) begin
        lvl = 4'(n);
      end
    end
    return lvl;
  endfunction : top_level

  // state
  pic_src_t src_q;
  logic [31:0] sys_prev_q;
  logic err15_q;
  logic [15:1] soft_q;
  logic [31:0] mask_q;
  logic [31:0] evt_stat_q;
  logic [31:0] evt_en_q;
  pic_bus_st_t st_q;
  pic_bus_st_t st_d;
  pic_apb_rsp_t rsp_q;
  logic [3:0] level_q;
  logic irq_q;

  // derived
  logic [31:0] sys_pend;
  logic [31:0] sys_on;
  logic [15:1] hw_lvl;
  logic [15:1] req_all;
  logic [31:0] cpu_pend;
  logic [31:0] evt_set;
  logic [31:0] evt_stat_d;
  logic [NUM_REGS-1:0] sel;
  logic wr_fire;
  logic [31:0] rd_data;

  // sample the request levels once so all state sees the same copy
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      src_q <= '0;
    end else begin
      src_q <= I_SRC;
    end
  end

  // level-15 latch: errors and power-down are held until cleared
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      err15_q <= 1'b0;
    end else if (src_q.hw_error || src_q.power_down) begin
      err15_q <= 1'b1;
    end else if (wr_fire && sel[1] && I_APB.pwdata[LEVEL15_CLEAR_POS]) begin
      err15_q <= 1'b0;
    end
  end

  // system pending word; reserved bits stay zero
  always_comb begin
    sys_pend = '0;
    sys_pend[MODULE_ERROR_POS] = err15_q;
    sys_pend[FLOPPY_POS] = src_q.floppy;
    sys_pend[SYS_TIMER_POS] = src_q.sys_timer;
    sys_pend[DISK_BUS_POS] = src_q.disk_bus;
    sys_pend[NETWORK_POS] = src_q.network;
    sys_pend[SERIAL_POS] = src_q.serial;
    sys_pend[KBD_MOUSE_POS] = src_q.kbd_mouse;
    sys_pend[EXP_LSB +: 7] = src_q.expansion;
  end

  // a set mask bit blocks that source's level; bit 31 blocks every level, but not the event line
  assign sys_on = sys_pend & ~mask_q;

  // route enabled sources onto their fixed levels
  always_comb begin
    hw_lvl = '0;
    hw_lvl[LVL_SYS_TIMER] = sys_on[SYS_TIMER_POS];
    hw_lvl[LVL_FLOPPY] = sys_on[FLOPPY_POS];
    hw_lvl[LVL_SERIAL] = sys_on[SERIAL_POS] | sys_on[KBD_MOUSE_POS];
    hw_lvl[LVL_AUDIO] = src_q.audio;
    hw_lvl[LVL_CPU_TIMER] = src_q.cpu_timer;
    hw_lvl[LVL_PARALLEL] = src_q.parallel;
    hw_lvl[LVL_DISK_BUS] = sys_on[DISK_BUS_POS];
    hw_lvl[LVL_NETWORK] = sys_on[NETWORK_POS];
    hw_lvl[LVL_ERROR] = sys_on[MODULE_ERROR_POS];
    // shared levels (3, 11, 13) are or-ed, not overwritten
    for (int i = 1; i <= 7; i++) begin
      if (sys_on[EXP_LSB+i-1]) begin
        hw_lvl[EXP_LVL_MAP[(i-1)*4 +: 4]] = 1'b1;
      end
    end
    if (mask_q[GLOBAL_DISABLE_POS]) begin
      hw_lvl = '0;
    end
  end

  // software requests are gated by the global disable as well
  assign req_all = mask_q[GLOBAL_DISABLE_POS] ? '0 : (soft_q | hw_lvl);

  // processor pending view: software above bit 16, hardware below
  always_comb begin
    cpu_pend = '0;
    cpu_pend[SOFT_LSB+1 +: 15] = soft_q;
    cpu_pend[15:1] = hw_lvl;
  end

  // software request bits
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      soft_q <= SOFT_RST;
    end else if (wr_fire && sel[2]) begin
      soft_q <= soft_q | I_APB.pwdata[SOFT_LSB+1 +: 15];
    end else if (wr_fire && sel[1]) begin
      soft_q <= soft_q & ~I_APB.pwdata[SOFT_LSB+1 +: 15];
    end
  end

  // system mask: only the clear and set words change it
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_q <= SYS_MASK_RST;
    end else if (wr_fire && sel[5]) begin
      mask_q <= mask_q & ~(I_APB.pwdata & SYS_IMPL_BITS);
    end else if (wr_fire && sel[6]) begin
      mask_q <= mask_q | (I_APB.pwdata & SYS_IMPL_BITS);
    end
  end

  // rising edge of any system pending bit is an event
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      sys_prev_q <= '0;
    end else begin
      sys_prev_q <= sys_pend;
    end
  end

  // one sticky flag per system bit; a new edge beats a clear
  generate
    for (genvar b = 0; b < 32; b++) begin : g_evt
      assign evt_set[b] = sys_pend[b] & ~sys_prev_q[b];
      always_comb begin
        evt_stat_d[b] = evt_stat_q[b];
        if (wr_fire && sel[8] && I_APB.pwdata[b]) begin
          evt_stat_d[b] = 1'b0;
        end
        if (evt_set[b]) begin
          evt_stat_d[b] = 1'b1;
        end
      end
    end
  endgenerate

  // event status and enable
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      evt_stat_q <= EVT_RST;
      evt_en_q <= EVT_RST;
    end else begin
      evt_stat_q <= evt_stat_d;
      if (wr_fire && sel[9]) begin
        evt_en_q <= I_APB.pwdata & SYS_IMPL_BITS;
      end
    end
  end

  // interrupt line follows the enabled sticky flags
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evt_stat_d & evt_en_q);
    end
  end

  // encoded level, one clock behind the requests
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      level_q <= 4'h0;
    end else begin
      level_q <= top_level(req_all);
    end
  end

  // bus decode; writes land only on the completing edge
  assign sel = reg_sel(I_APB.paddr);
  assign wr_fire = st_q[2] && I_APB.psel && I_APB.penable && I_APB.pwrite;

  // read mux; write-only words read as zero
  always_comb begin
    rd_data = '0;
    unique case (1'b1)
      sel[0]: rd_data = cpu_pend;
      sel[3]: rd_data = sys_pend;
      sel[4]: rd_data = mask_q;
      sel[7]: rd_data = evt_stat_q;
      sel[9]: rd_data = evt_en_q;
      default: rd_data = '0;
    endcase
  end

  // handshake: one wait cycle so every answer comes from a flop
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (I_APB.psel && !I_APB.penable) begin
          st_d = ST_ACC;
        end
      end
      ST_ACC: begin
        st_d = ST_RSP;
      end
      ST_RSP: begin
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // response: data caught in setup, ready raised for exactly one cycle
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rsp_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (I_APB.psel && !I_APB.penable) begin
            rsp_q.prdata <= I_APB.pwrite ? 32'h0000_0000 : rd_data;
            rsp_q.pslverr <= 1'b0;
          end
          rsp_q.pready <= 1'b0;
        end
        ST_ACC: begin
          rsp_q.pready <= 1'b1;
          rsp_q.pslverr <= ~|sel; // unmapped address
        end
        default: begin
          rsp_q.pready <= 1'b0;
          rsp_q.pslverr <= 1'b0;
        end
      endcase
    end
  end

  // outputs straight from flops
  assign O_APB = rsp_q;
  assign O_CPU_IRQ_LEVEL = level_q;
  assign O_IRQ = irq_q;

endmodule : pic_ctrl

`default_nettype wire

// ### pic_ctrl_assertions.sv
// checker: bus timing, mask mirror and level relations
`timescale 1ns/1ps
`default_nettype none
module pic_ctrl_checker
  import pic_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // register bus and sources
  input wire pic_apb_req_t I_APB,
  input wire pic_apb_rsp_t O_APB,
  input wire pic_src_t I_SRC,
  // outputs
  input wire logic [3:0] O_CPU_IRQ_LEVEL,
  input wire logic O_IRQ
);
  logic [31:0] mask_q;
  logic wr_done;
  logic rd_done;
  logic [3:0] lvl;
  // completed transfers only; a stalled access must not count
  assign wr_done = I_APB.psel && I_APB.penable && O_APB.pready && I_APB.pwrite;
  assign rd_done = I_APB.psel && I_APB.penable && O_APB.pready && !I_APB.pwrite;
  assign lvl = O_CPU_IRQ_LEVEL;
  // mask mirror, all masked after reset
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      mask_q <= SYS_MASK_RST;
    end else if (wr_done && I_APB.paddr == SYS_IRQ_MASK_CLEAR_ADDR) begin
      mask_q <= mask_q & ~(I_APB.pwdata & SYS_IMPL_BITS);
    end else if (wr_done && I_APB.paddr == SYS_IRQ_MASK_SET_ADDR) begin
      mask_q <= mask_q | (I_APB.pwdata & SYS_IMPL_BITS);
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_ready_time: assert property (I_APB.psel && !I_APB.penable |-> ##2 O_APB.pready)
    else $error("bus answer late");
  a_err_ready: assert property (O_APB.pslverr |-> O_APB.pready)
    else $error("error without ready");
  a_mask_read: assert property (rd_done && I_APB.paddr == SYS_IRQ_MASK_ADDR
    |-> O_APB.prdata == mask_q) else $error("mask readback differs");
  a_wo_zero: assert property (rd_done && I_APB.paddr == SYS_IRQ_MASK_SET_ADDR
    |-> O_APB.prdata == 32'h0000_0000) else $error("write-only word nonzero");
  a_global_off: assert property (mask_q[31] [*3] |-> lvl == 4'h0)
    else $error("level while all disabled");
  a_error_top: assert property ((I_SRC.hw_error && !mask_q[31] && !mask_q[30]) [*4]
    |-> lvl == 4'hF) else $error("error not at top level");
  a_net_floor: assert property ((I_SRC.network && !mask_q[31] && !mask_q[16]) [*3]
    |-> lvl >= 4'h6) else $error("network below its level");
  a_timer_floor: assert property ((I_SRC.cpu_timer && !mask_q[31]) [*3] |-> lvl >= 4'hE)
    else $error("timer below its level");
  a_soft_top: assert property (wr_done && I_APB.paddr == CPU_SOFT_IRQ_SET_ADDR &&
    I_APB.pwdata[31] && !mask_q[31] |-> ##2 lvl == 4'hF) else $error("soft level late");
  // main scenarios reached
  c_top: cover property (lvl == 4'hF);
  c_err: cover property (O_APB.pslverr);
  c_irq: cover property (O_IRQ);
endmodule : pic_ctrl_checker
bind pic_ctrl pic_ctrl_checker i_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_APB(I_APB),
  .O_APB(O_APB), .I_SRC(I_SRC), .O_CPU_IRQ_LEVEL(O_CPU_IRQ_LEVEL), .O_IRQ(O_IRQ));
`default_nettype wire

// ### pic_pkg.sv
// package: register map, field layout and types of the interrupt controller
package pic_pkg;
  // register byte addresses
  localparam logic [31:0] CPU_IRQ_PENDING_ADDR = 32'h71E0_0000;
  localparam logic [31:0] CPU_IRQ_CLEAR_ADDR = 32'h71E0_0004;
  localparam logic [31:0] CPU_SOFT_IRQ_SET_ADDR = 32'h71E0_0008;
  localparam logic [31:0] SYS_IRQ_PENDING_ADDR = 32'h71E1_0000;
  localparam logic [31:0] SYS_IRQ_MASK_ADDR = 32'h71E1_0004;
  localparam logic [31:0] SYS_IRQ_MASK_CLEAR_ADDR = 32'h71E1_0008;
  localparam logic [31:0] SYS_IRQ_MASK_SET_ADDR = 32'h71E1_000C;
  localparam logic [31:0] EVT_STATUS_ADDR = 32'h71E1_0010;
  localparam logic [31:0] EVT_CLEAR_ADDR = 32'h71E1_0014;
  localparam logic [31:0] EVT_ENABLE_ADDR = 32'h71E1_0018;
  localparam int NUM_REGS = 10;

  // processor register layout: software level n at SOFT_LSB+n, hardware at n
  localparam int SOFT_LSB = 16;
  localparam int LEVEL15_CLEAR_POS = 15;

  // system mask / pending field positions
  localparam int GLOBAL_DISABLE_POS = 31;
  localparam int MODULE_ERROR_POS = 30;
  localparam int FLOPPY_POS = 22;
  localparam int SYS_TIMER_POS = 19;
  localparam int DISK_BUS_POS = 18;
  localparam int NETWORK_POS = 16;
  localparam int SERIAL_POS = 15;
  localparam int KBD_MOUSE_POS = 14;
  localparam int EXP_LSB = 7;

  // fixed request levels
  localparam int LVL_SYS_TIMER = 10;
  localparam int LVL_FLOPPY = 11;
  localparam int LVL_SERIAL = 12;
  localparam int LVL_AUDIO = 13;
  localparam int LVL_CPU_TIMER = 14;
  localparam int LVL_PARALLEL = 3;
  localparam int LVL_DISK_BUS = 4;
  localparam int LVL_NETWORK = 6;
  localparam int LVL_ERROR = 15;
  // expansion request i (1..7) level in nibble i-1
  localparam logic [27:0] EXP_LVL_MAP = 28'hDB9_7532;

  // reset values and implemented bits
  localparam logic [31:0] SYS_IMPL_BITS = 32'hC04D_FF80;
  localparam logic [31:0] SYS_MASK_RST = SYS_IMPL_BITS;
  localparam logic [15:1] SOFT_RST = 15'h0000;
  localparam logic [31:0] EVT_RST = 32'h0000_0000;

  // bus handshake states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACC = 3'b010,
    ST_RSP = 3'b100
  } pic_bus_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } pic_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pic_apb_rsp_t;

  // hardware request inputs, all active high levels
  typedef struct packed {
    logic sys_timer;
    logic floppy;
    logic serial;
    logic kbd_mouse;
    logic audio;
    logic cpu_timer;
    logic parallel;
    logic disk_bus;
    logic network;
    logic hw_error;
    logic power_down;
    logic [7:1] expansion;
  } pic_src_t;
endpackage : pic_pkg

// ### priority_interrupt_controller_bench.sv
// testbench: source table, register traffic and awkward cases
`timescale 1ns/1ps
`default_nettype none
module priority_interrupt_controller_bench
  import pic_pkg::*;
();
  logic clk;
  logic rst;
  pic_apb_req_t req;
  pic_apb_rsp_t rsp;
  pic_src_t src;
  logic [3:0] level;
  logic [3:0] taken;
  logic irq;
  logic [31:0] rd;
  logic er;
  int fails = 0;
  int compares = 0;
  // source pattern over expected level, one source at a time
  logic [21:0] rows [16] = '{22'h20_000A, 22'h10_000B, 22'h8_000C, 22'h4_000C, 22'h2_000D,
    22'h1_000E, 22'h8003, 22'h4004, 22'h2006, 22'h0012, 22'h0023, 22'h0045, 22'h0087,
    22'h0109, 22'h020B, 22'h040D};
  pic_ctrl i_dut (.I_CLK(clk), .I_RST(rst), .I_APB(req), .O_APB(rsp), .I_SRC(src),
    .O_CPU_IRQ_LEVEL(level), .O_IRQ(irq));
  pic_cpu_model i_cpu (.I_CLK(clk), .i_level(level), .o_taken(taken));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 32);
    r = rsp.prdata;
    e = rsp.pslverr;
    if (n >= 32) begin
      fails++;
      tally_and_finish();
    end
    req <= '0;
  endtask : apb
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdchk(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, rd, er);
    chk(rd, x);
  endtask : rdchk
  task automatic lchk(input logic [3:0] x);
    chk(32'(level), 32'(x));
  endtask : lchk
  // main sequence
  initial begin
    rst <= 1'b1;
    req <= '0;
    src <= '0;
    tick(16);
    rst <= 1'b0;
    wr(SYS_IRQ_MASK_CLEAR_ADDR, 32'hFFFF_FFFF);
    rdchk(SYS_IRQ_MASK_ADDR, 32'h0000_0000);
    foreach (rows[k]) begin
      src <= pic_src_t'(rows[k][21:4]);
      tick(4);
      chk(32'(taken), 32'(rows[k][3:0]));
      src <= '0;
      tick(3);
    end
    // global disable beats a live source, then a single mask bit
    src <= 18'h0200;
    wr(SYS_IRQ_MASK_SET_ADDR, 32'h8000_0000);
    tick(2);
    lchk(4'h0);
    wr(SYS_IRQ_MASK_CLEAR_ADDR, 32'h8000_0000);
    tick(2);
    lchk(4'h6);
    rdchk(CPU_IRQ_PENDING_ADDR, 32'h0000_0040);
    wr(SYS_IRQ_MASK_SET_ADDR, 32'h0001_0000);
    tick(2);
    lchk(4'h0);
    rdchk(SYS_IRQ_MASK_ADDR, 32'h0001_0000);
    // event line: raise, mask, clear; loop left stale status behind
    wr(EVT_ENABLE_ADDR, 32'h0001_0000);
    src <= '0;
    wr(SYS_IRQ_MASK_CLEAR_ADDR, 32'h0001_0000);
    wr(EVT_CLEAR_ADDR, 32'hFFFF_FFFF);
    tick(3);
    chk(32'(irq), 32'h0);
    src <= 18'h0200;
    tick(4);
    chk(32'(irq), 32'h1);
    wr(EVT_ENABLE_ADDR, 32'h0000_0000);
    tick(3);
    chk(32'(irq), 32'h0);
    wr(EVT_ENABLE_ADDR, 32'h0001_0000);
    tick(3);
    chk(32'(irq), 32'h1);
    rdchk(EVT_STATUS_ADDR, 32'h0001_0000);
    wr(EVT_CLEAR_ADDR, 32'h0001_0000);
    tick(3);
    chk(32'(irq), 32'h0);
    // every source but error and power-down live at once: bit positions and top level
    src <= 18'h3_FE7F;
    tick(2);
    rdchk(SYS_IRQ_PENDING_ADDR, 32'h004D_FF80);
    lchk(4'hE);
    src <= '0;
    // power-down then hardware error: sticky top level until cleared
    for (int k = 7; k < 9; k++) begin
      src <= pic_src_t'(18'h1 << k);
      tick(4);
      src <= '0;
      tick(2);
      lchk(4'hF);
      rdchk(SYS_IRQ_PENDING_ADDR, 32'h4000_0000);
      wr(CPU_IRQ_CLEAR_ADDR, 32'h0000_8000);
      tick(2);
      lchk(4'h0);
    end
    // every software level: set, read back, clear
    for (int n = 1; n < 16; n++) begin
      wr(CPU_SOFT_IRQ_SET_ADDR, 32'h1 << (16 + n));
      tick(2);
      lchk(4'(n));
      rdchk(CPU_IRQ_PENDING_ADDR, 32'h1 << (16 + n));
      wr(CPU_IRQ_CLEAR_ADDR, 32'h1 << (16 + n));
      tick(2);
      lchk(4'h0);
    end
    // unmapped word, write to a read-only word, read of a write-only word
    apb(1'b0, 32'h71E1_001C, 32'h0000_0000, rd, er);
    chk(32'(er), 32'h1);
    wr(SYS_IRQ_MASK_ADDR, 32'hFFFF_FFFF);
    rdchk(SYS_IRQ_MASK_ADDR, 32'h0000_0000);
    rdchk(SYS_IRQ_MASK_SET_ADDR, 32'h0000_0000);
    // reset in mid-run with a soft request and a source live
    src <= 18'h0200;
    wr(CPU_SOFT_IRQ_SET_ADDR, 32'h8000_0000);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    lchk(4'h0);
    chk(32'(irq), 32'h0);
    rdchk(SYS_IRQ_MASK_ADDR, SYS_MASK_RST);
    tally_and_finish();
  end
endmodule : priority_interrupt_controller_bench
`default_nettype wire
